/* File: cab_address_unit.sv */
`timescale 1ns/1ps
`default_nettype none
// address generation, stack, temporary byte, output data selector and bus strobes
module cab_address_unit #(
  parameter logic [15:0] PC_RESET_VALUE = cab_pkg::PC_RESET,
  parameter logic [15:0] SP_RESET_VALUE = cab_pkg::SP_RESET,
  parameter logic [7:0] INT_OPCODE = cab_pkg::INT_OPCODE_DEFAULT
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ready,
  input wire cab_pkg::cab_ctrl_t i_ctrl,
  input wire logic [7:0] i_alu_result,
  input wire logic [7:0] i_reg_read_data,
  input wire logic [7:0] i_input_data_bus,
  input wire logic [7:0] i_interrupt_request,
  input wire cab_pkg::cab_flag_ctl_t i_flag_ctl,
  output logic [15:0] o_next_address,
  output logic [15:0] o_address,
  output logic [7:0] o_output_data_bus,
  output logic o_read,
  output logic o_write,
  output logic o_opcode_fetch_strobe,
  output logic [7:0] o_opcode,
  output logic o_int_accepted,
  output logic [2:0] o_int_line,
  output logic [7:0] o_temp,
  output logic [15:0] o_program_counter,
  output logic [15:0] o_stack_pointer,
  output logic [7:0] o_status_flags_word
);

  // counter controls, next-cycle values and status nets
  logic hold;
  logic [15:0] pc_count;
  logic [15:0] sp_count;
  logic [15:0] sp_minus;
  logic [15:0] alu_temp_addr;
  logic [15:0] next_address;
  logic next_read;
  logic next_write;
  logic next_fetch;
  logic pc_load;
  logic pc_inc;
  logic sp_load;
  logic [15:0] sp_load_value;
  logic sp_inc;
  logic sp_dec;
  logic [7:0] next_dout;
  logic [7:0] status_word;
  logic int_pending;
  logic [2:0] int_line;
  logic data_sampled;

  // low ready freezes every flip-flop of the unit except the registered state copies
  // every process below except the registered copies qualifies its update with hold, so a stalled bus cycle repeats
  assign hold = !i_ready;

  // indexed and jump targets: high byte from the arithmetic unit, low byte from temp
  assign alu_temp_addr = {i_alu_result, o_temp};

  // a read completes at the edge that ends its strobed cycle, unless frozen
  assign data_sampled = o_read && i_ready;

  // program counter
  cab_counter #(
    .WIDTH(cab_pkg::ADDR_W),
    .RESET_VALUE(PC_RESET_VALUE)
  ) u_pc (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_hold(hold),
    .i_load(pc_load),
    .i_load_value(alu_temp_addr),
    .i_inc(pc_inc),
    .i_dec(1'b0),
    .o_count(pc_count),
    .o_count_minus()
  );

  // stack pointer
  cab_counter #(
    .WIDTH(cab_pkg::ADDR_W),
    .RESET_VALUE(SP_RESET_VALUE)
  ) u_sp (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_hold(hold),
    .i_load(sp_load),
    .i_load_value(sp_load_value),
    .i_inc(sp_inc),
    .i_dec(sp_dec),
    .o_count(sp_count),
    .o_count_minus(sp_minus)
  );

  // status flags and interrupt qualification
  cab_status u_status (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_hold(hold),
    .i_flag_ctl(i_flag_ctl),
    .i_interrupt_request(i_interrupt_request),
    .o_status_flags_word(status_word),
    .o_int_pending(int_pending),
    .o_int_line(int_line)
  );

  // counter steering from the current command
  always_comb
  begin
    pc_load = 1'b0;
    pc_inc = 1'b0;
    sp_load = 1'b0;
    sp_load_value = sp_count;
    sp_inc = 1'b0;
    sp_dec = 1'b0;
    case (i_ctrl.cmd)
      cab_pkg::CMD_FETCH:
        pc_inc = 1'b1;
      cab_pkg::CMD_OPERAND:
        pc_inc = 1'b1;
      cab_pkg::CMD_JUMP:
        pc_load = 1'b1;
      cab_pkg::CMD_PUSH:
        sp_dec = 1'b1;
      cab_pkg::CMD_POP:
        sp_inc = 1'b1;
      cab_pkg::CMD_LOAD_SP_LO:
      begin
        sp_load = 1'b1;
        sp_load_value = {sp_count[15:8], i_alu_result};
      end
      cab_pkg::CMD_LOAD_SP_HI:
      begin
        sp_load = 1'b1;
        sp_load_value = {i_alu_result, sp_count[7:0]};
      end
      default:
      begin
        pc_load = 1'b0;
      end
    endcase
  end

  // next address and strobes for the following cycle
  // idle, stack-pointer load and temp load commands leave the previous address on the bus
  always_comb
  begin
    next_address = o_address;
    next_read = 1'b0;
    next_write = 1'b0;
    next_fetch = 1'b0;
    case (i_ctrl.cmd)
      cab_pkg::CMD_FETCH:
      begin
        next_address = pc_count;
        next_read = 1'b1;
        next_fetch = 1'b1;
      end
      cab_pkg::CMD_OPERAND:
      begin
        next_address = pc_count;
        next_read = 1'b1;
      end
      cab_pkg::CMD_READ_IDX:
      begin
        next_address = alu_temp_addr;
        next_read = 1'b1;
      end
      cab_pkg::CMD_WRITE_IDX:
      begin
        next_address = alu_temp_addr;
        next_write = 1'b1;
      end
      cab_pkg::CMD_JUMP:
        next_address = alu_temp_addr;
      cab_pkg::CMD_PUSH:
      begin
        next_address = sp_minus;
        next_write = 1'b1;
      end
      cab_pkg::CMD_POP:
      begin
        next_address = sp_count;
        next_read = 1'b1;
      end
      default:
      begin
        next_address = o_address;
      end
    endcase
  end

  // early address for one-cycle-ahead decoding
  assign o_next_address = next_address;

  // three-way output data selector
  always_comb
  begin
    case (i_ctrl.dout_sel)
      cab_pkg::DOUT_PC_HI:
        next_dout = pc_count[15:8];
      cab_pkg::DOUT_PC_LO:
        next_dout = pc_count[7:0];
      default:
        next_dout = i_reg_read_data;
    endcase
  end

  // external address bus, registered from the next address
  // a flop-driven bus leaves the whole cycle for decode into memory
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      o_address <= cab_pkg::PC_RESET;
    else if (!hold)
      o_address <= next_address;
  end

  // bus strobes, each straight from a flip-flop
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_read <= 1'b0;
      o_write <= 1'b0;
      o_opcode_fetch_strobe <= 1'b0;
    end
    else if (!hold)
    begin
      o_read <= next_read;
      o_write <= next_write;
      o_opcode_fetch_strobe <= next_fetch;
    end
  end

  // output data registered alongside the write strobe so both stand together
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      o_output_data_bus <= 8'h00;
    else if (!hold && next_write)
      o_output_data_bus <= next_dout;
  end

  // temporary byte: operand, popped and indexed read data, or an arithmetic result
  // a read completing at this edge beats a temp load, so the decoder
  // must not issue a temp load directly behind an operand, pop or indexed read
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      o_temp <= 8'h00;
    else if (data_sampled && !o_opcode_fetch_strobe)
      o_temp <= i_input_data_bus;
    else if (!hold && i_ctrl.cmd == cab_pkg::CMD_LOAD_TEMP)
      o_temp <= i_alu_result;
  end

  // opcode register; reset and accepted interrupts force the interrupt opcode
  // interrupts are judged only as a fetch completes, never mid-instruction
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_opcode <= INT_OPCODE;
      o_int_accepted <= 1'b0;
      o_int_line <= 3'h0;
    end
    else if (data_sampled && o_opcode_fetch_strobe)
    begin
      o_int_accepted <= int_pending;
      o_int_line <= int_line;
      if (int_pending)
        o_opcode <= INT_OPCODE;
      else
        o_opcode <= i_input_data_bus;
    end
    else if (!hold)
      o_int_accepted <= 1'b0;
  end

  // registered copies of internal state for the rest of the core
  // not gated by ready: while frozen they simply repeat the held values
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_program_counter <= PC_RESET_VALUE;
      o_stack_pointer <= SP_RESET_VALUE;
      o_status_flags_word <= cab_pkg::STATUS_RESET;
    end
    else
    begin
      o_program_counter <= pc_count;
      o_stack_pointer <= sp_count;
      o_status_flags_word <= status_word;
    end
  end

endmodule
`default_nettype wire

/* File: cab_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the address unit
module cab_chk (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ready,
  input wire cab_pkg::cab_ctrl_t i_ctrl,
  input wire logic [7:0] i_input_data_bus,
  input wire logic [7:0] i_interrupt_request,
  input wire cab_pkg::cab_flag_ctl_t i_flag_ctl,
  input wire logic [15:0] o_next_address,
  input wire logic [15:0] o_address,
  input wire logic o_read,
  input wire logic o_write,
  input wire logic o_opcode_fetch_strobe,
  input wire logic [7:0] o_opcode,
  input wire logic o_int_accepted,
  input wire logic [15:0] o_program_counter,
  input wire logic [15:0] o_stack_pointer,
  input wire logic [7:0] o_status_flags_word
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  logic fe, fo, pu, po;
  // commands taken at this edge
  assign fe = i_ready && i_ctrl.cmd == cab_pkg::CMD_FETCH;
  assign fo = fe || (i_ready && i_ctrl.cmd == cab_pkg::CMD_OPERAND);
  assign pu = i_ready && i_ctrl.cmd == cab_pkg::CMD_PUSH;
  assign po = i_ready && i_ctrl.cmd == cab_pkg::CMD_POP;
  chk_addr_reg: assert property (
    !$past(i_reset) && $past(i_ready) |-> o_address == $past(o_next_address))
    else $error("address is not the registered next address");
  chk_ready_hold: assert property (
    !i_ready |=> $stable(o_address) && $stable(o_read) && $stable(o_write) && $stable(o_opcode))
    else $error("state moved while ready low");
  chk_fetch_strobe: assert property (
    fe |=> o_read && o_opcode_fetch_strobe && !o_write)
    else $error("fetch strobes wrong");
  chk_write_cause: assert property (
    $rose(o_write) |-> $past(i_ctrl.cmd) inside {cab_pkg::CMD_PUSH, cab_pkg::CMD_WRITE_IDX})
    else $error("write strobe without write command");
  chk_pc_step: assert property (
    fo ##1 i_ready |=> o_program_counter == $past(o_next_address, 2) + 16'h0001)
    else $error("counter did not step");
  chk_push_sp: assert property (
    pu ##1 i_ready |=> o_stack_pointer == $past(o_address))
    else $error("stack pointer not on pushed byte");
  chk_pop_sp: assert property (
    po ##1 i_ready |=> o_stack_pointer == $past(o_address) + 16'h0001)
    else $error("stack pointer not past popped byte");
  chk_opcode_load: assert property (
    fe && i_interrupt_request == 8'h00 ##1 i_ready && i_interrupt_request == 8'h00
    |=> o_opcode == $past(i_input_data_bus) && !o_int_accepted)
    else $error("opcode not loaded");
  chk_nmi_take: assert property (
    fe ##1 i_ready && i_interrupt_request[0]
    |=> o_int_accepted && o_opcode == cab_pkg::INT_OPCODE_DEFAULT)
    else $error("line zero not taken");
  chk_user_flags: assert property (
    i_ready && |i_flag_ctl.user_set ##1 i_ready
    |=> &(o_status_flags_word[7:4] | ~$past(i_flag_ctl.user_set, 2)))
    else $error("user flag not set");
endmodule
`default_nettype wire

/* File: cab_counter.sv */
`timescale 1ns/1ps
`default_nettype none
// loadable up/down counter, used for program counter and stack pointer
module cab_counter #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_hold,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_load_value,
  input wire logic i_inc,
  input wire logic i_dec,
  output logic [WIDTH-1:0] o_count,
  output logic [WIDTH-1:0] o_count_minus
);

  // decremented value, offered early for pre-decrement addressing
  assign o_count_minus = o_count - WIDTH'(1);

  // load beats step; hold freezes the count
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      o_count <= RESET_VALUE;
    else if (!i_hold)
    begin
      if (i_load)
        o_count <= i_load_value;
      else if (i_inc)
        o_count <= o_count + WIDTH'(1);
      else if (i_dec)
        o_count <= o_count_minus;
    end
  end

endmodule
`default_nettype wire

/* File: cab_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// memory and decode model on the far side of the bus
module cab_mem (
  input wire logic i_sys_clk,
  input wire logic i_stall,
  input wire logic [15:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [7:0] i_data,
  output logic o_ready,
  output logic [7:0] o_data
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  initial foreach (mem[i]) mem[i] = i[7:0] ^ 8'h5a;
  // slow answers when the bench asks for a stall, never during reset
  assign o_ready = !i_stall;
  // read data only while read is high, else a pattern that moves
  assign o_data = i_read ? mem[i_address] : ~last;
  // store writes at the completing edge
  always @(posedge i_sys_clk)
  begin
    if (i_write && o_ready)
      mem[i_address] <= i_data;
    last <= o_data;
  end
endmodule
`default_nettype wire

/* File: cab_pkg.sv */
// How it works
// - next address is formed combinationally from arithmetic unit output and exposed early
// - external address bus is the registered copy of the next address
// - 16-bit program counter supplies the address of every opcode fetch
// - program counter steps by one per opcode fetch and per operand read
// - program counter reloads on jump, branch and interrupt processing
// - 16-bit up/down stack pointer addresses every push and pop
// - stack pointer always points at the most recently pushed byte
// - an 8-bit temporary register holds intermediate operand or address bytes
// - output data bus comes from a three-way selector: registers, pc high, pc low
// - pc bytes are selected onto the output bus when saving a return address
// - read strobe is high in every cycle the input data bus is sampled
// - write strobe comes from a flip-flop, high only while output data valid
// - all flip-flops clock on the rising edge of the single clock
// - interrupt line zero is non-maskable and ignores the mask bit
// - low ready freezes all state except the registered state copies; pending operation completes once ready returns
// - opcode fetch strobe is high in each cycle an opcode is fetched
// - upper four flag bits are set and cleared by their own inputs
// - maskable interrupts are ignored while status bit 3 is one
// - accepted interrupt or reset forces the interrupt opcode into the opcode register
package cab_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int INT_LINES = 8;
  localparam int USER_FLAGS = 4;

  // status flags word field positions
  localparam int FLAG_Z = 0;
  localparam int FLAG_C = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_MASK = 3;
  localparam int FLAG_USER_LO = 4;

  // reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h01ff;
  localparam logic [7:0] STATUS_RESET = 8'h08;
  localparam logic [7:0] INT_OPCODE_DEFAULT = 8'h00;

  // minimum reset hold, in rising edges
  localparam int RESET_HOLD_EDGES = 3;

  // commands issued by the instruction decoder, one per cycle
  typedef enum logic [3:0] {
    CMD_IDLE,
    CMD_FETCH,
    CMD_OPERAND,
    CMD_READ_IDX,
    CMD_WRITE_IDX,
    CMD_PUSH,
    CMD_POP,
    CMD_JUMP,
    CMD_LOAD_SP_LO,
    CMD_LOAD_SP_HI,
    CMD_LOAD_TEMP
  } cab_cmd_t;

  // output data selector
  typedef enum logic [1:0] {
    DOUT_REGS,
    DOUT_PC_HI,
    DOUT_PC_LO
  } cab_dout_sel_t;

  typedef struct packed {
    cab_cmd_t cmd;
    cab_dout_sel_t dout_sel;
  } cab_ctrl_t;

  // flag update inputs from the arithmetic unit and decoder
  typedef struct packed {
    logic alu_load;
    logic [2:0] alu_nzc;
    logic mask_set;
    logic mask_clear;
    logic [3:0] user_set;
    logic [3:0] user_clear;
  } cab_flag_ctl_t;

endpackage

/* File: cab_status.sv */
`timescale 1ns/1ps
`default_nettype none
// status flags word and interrupt qualification
module cab_status (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_hold,
  input wire cab_pkg::cab_flag_ctl_t i_flag_ctl,
  input wire logic [7:0] i_interrupt_request,
  output logic [7:0] o_status_flags_word,
  output logic o_int_pending,
  output logic [2:0] o_int_line
);

  logic [7:0] next_flags;
  logic maskable_req;

  // flag updates; a set wins over a clear in the same cycle
  always_comb
  begin
    next_flags = o_status_flags_word;
    if (i_flag_ctl.alu_load)
    begin
      next_flags[cab_pkg::FLAG_Z] = i_flag_ctl.alu_nzc[0];
      next_flags[cab_pkg::FLAG_C] = i_flag_ctl.alu_nzc[1];
      next_flags[cab_pkg::FLAG_N] = i_flag_ctl.alu_nzc[2];
    end
    if (i_flag_ctl.mask_clear)
      next_flags[cab_pkg::FLAG_MASK] = 1'b0;
    if (i_flag_ctl.mask_set)
      next_flags[cab_pkg::FLAG_MASK] = 1'b1;
    for (int i = 0; i < cab_pkg::USER_FLAGS; i++)
    begin
      if (i_flag_ctl.user_clear[i])
        next_flags[cab_pkg::FLAG_USER_LO + i] = 1'b0;
      if (i_flag_ctl.user_set[i])
        next_flags[cab_pkg::FLAG_USER_LO + i] = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      o_status_flags_word <= cab_pkg::STATUS_RESET;
    else if (!i_hold)
      o_status_flags_word <= next_flags;
  end

  // line zero bypasses the mask, the rest obey it
  assign maskable_req = (|i_interrupt_request[7:1]) & ~o_status_flags_word[cab_pkg::FLAG_MASK];
  assign o_int_pending = i_interrupt_request[0] | maskable_req;

  // lowest numbered active line wins
  always_comb
  begin
    o_int_line = 3'h0;
    if (!i_interrupt_request[0] && maskable_req)
    begin
      for (int i = 7; i >= 1; i--)
        if (i_interrupt_request[i])
          o_int_line = 3'(i);
    end
  end

endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_sys_clk = 0;
  logic i_reset = 1;
  logic stall = 0; // ready stays high in reset
  logic i_ready;
  cab_pkg::cab_ctrl_t i_ctrl = '0;
  cab_pkg::cab_dout_sel_t sel = cab_pkg::DOUT_REGS;
  cab_pkg::cab_flag_ctl_t fc = '0;
  cab_pkg::cab_flag_ctl_t fl = '0;
  logic [7:0] alu = 0, regd = 0, irq = 0, din, dout, opc, tmp, status_flags_word, t = 0, tp = 0;
  logic tv = 0; // a read whose data reaches temp at the next taken edge
  logic [15:0] nxt, adr, pcc, spc, pc = 0, sp = 16'h01ff;
  logic rd, wr, ofs, ia;
  logic [2:0] il;
  logic [31:0] s = 20;
  logic [25:0] exq[$];
  bit [7:0] rm[int];
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  cab_address_unit dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ready(i_ready),
    .i_ctrl(i_ctrl), .i_alu_result(alu), .i_reg_read_data(regd), .i_input_data_bus(din),
    .i_interrupt_request(irq), .i_flag_ctl(fl), .o_next_address(nxt), .o_address(adr),
    .o_output_data_bus(dout), .o_read(rd), .o_write(wr), .o_opcode_fetch_strobe(ofs),
    .o_opcode(opc), .o_int_accepted(ia), .o_int_line(il), .o_temp(tmp),
    .o_program_counter(pcc), .o_stack_pointer(spc), .o_status_flags_word(status_flags_word));
  cab_mem mem (.i_sys_clk(i_sys_clk), .i_stall(stall), .i_address(adr), .i_read(rd),
    .i_write(wr), .i_data(dout), .o_ready(i_ready), .o_data(din));
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] mv(input logic [15:0] a);
    return rm.exists(a) ? rm[a] : a[7:0] ^ 8'h5a;
  endfunction
  task automatic chk(input logic [25:0] seen, input logic [25:0] want);
    n_compared++;
    if (seen !== want)
    begin
      num_errors++;
      $display("wrong value at %0t: %h not %h", $time, seen, want);
    end
  endtask
  task automatic test_done;
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // drive one command until taken, then note the bus transfer it causes
  task automatic cmd(input cab_pkg::cab_cmd_t c, input logic [7:0] a);
    logic [15:0] ea;
    logic [7:0] ed;
    @(negedge i_sys_clk);
    i_ctrl = '{c, sel};
    alu = a;
    regd = 8'(rnd());
    fl = fc;
    fc = '0;
    stall = rnd() % 4 == 0;
    ea = {a, t};
    ed = sel == cab_pkg::DOUT_PC_HI ? pc[15:8] : sel == cab_pkg::DOUT_PC_LO ? pc[7:0] : regd;
    if (c == cab_pkg::CMD_FETCH || c == cab_pkg::CMD_OPERAND)
      ea = pc;
    if (c == cab_pkg::CMD_PUSH)
      ea = sp - 16'h0001;
    if (c == cab_pkg::CMD_POP)
      ea = sp;
    #1;
    if (c != cab_pkg::CMD_IDLE && c < cab_pkg::CMD_LOAD_SP_LO)
      chk({10'h0, nxt}, {10'h0, ea});
    forever
    begin
      @(posedge i_sys_clk);
      if (i_ready)
        break;
      @(negedge i_sys_clk);
      stall = 0;
    end
    if (c == cab_pkg::CMD_WRITE_IDX || c == cab_pkg::CMD_PUSH)
      rm[ea] = ed;
    // temp model: a completing operand, pop or indexed read wins over a temp load
    if (tv)
      t = tp;
    else if (c == cab_pkg::CMD_LOAD_TEMP)
      t = a;
    tv = c inside {cab_pkg::CMD_OPERAND, cab_pkg::CMD_POP, cab_pkg::CMD_READ_IDX};
    tp = mv(ea);
    case (c)
      cab_pkg::CMD_FETCH, cab_pkg::CMD_OPERAND, cab_pkg::CMD_POP, cab_pkg::CMD_READ_IDX:
        exq.push_back({c == cab_pkg::CMD_FETCH, 1'b0, ea, 8'h00});
      cab_pkg::CMD_WRITE_IDX, cab_pkg::CMD_PUSH:
        exq.push_back({2'b01, ea, ed});
      cab_pkg::CMD_JUMP: pc = ea;
      cab_pkg::CMD_LOAD_SP_LO: sp[7:0] = a;
      cab_pkg::CMD_LOAD_SP_HI: sp[15:8] = a;
      default: ;
    endcase
    if (c == cab_pkg::CMD_FETCH || c == cab_pkg::CMD_OPERAND)
      pc++;
    if (c == cab_pkg::CMD_PUSH)
      sp--;
    if (c == cab_pkg::CMD_POP)
      sp++;
  endtask
  task automatic idles(input int n);
    repeat (n) cmd(cab_pkg::CMD_IDLE, 8'h00);
  endtask
  // fetch with a given request level and check opcode, acceptance and line
  task automatic fetch(input logic [7:0] rq, input logic tk, input logic [2:0] ln);
    logic [7:0] w;
    @(negedge i_sys_clk);
    irq = rq;
    i_ctrl.cmd = cab_pkg::CMD_IDLE;
    fl = '0;
    w = tk ? cab_pkg::INT_OPCODE_DEFAULT : mv(pc);
    cmd(cab_pkg::CMD_FETCH, 8'h00);
    idles(1);
    @(negedge i_sys_clk);
    chk({14'h0, ia, opc, il}, {14'h0, tk, w, ln});
    irq = 8'h00;
  endtask
  // compare each completed bus transfer with the oldest note
  always @(negedge i_sys_clk)
  begin
    #2;
    if (!i_reset && i_ready && (rd || wr))
      chk({ofs, wr, adr, wr ? dout : 8'h00}, exq.size() ? exq.pop_front() : '1);
  end
  // cut a hang short
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      test_done;
    end
  end
  initial
  begin
    repeat (20) @(negedge i_sys_clk);
    chk({2'b00, adr, opc}, 26'h0);
    chk({2'b00, spc, status_flags_word}, {2'b00, 16'h01ff, 8'h08});
    i_reset = 0;
    fetch(8'h00, 0, 0);
    cmd(cab_pkg::CMD_OPERAND, 8'h00);
    cmd(cab_pkg::CMD_OPERAND, 8'h00);
    fetch(8'h04, 0, 0);
    fetch(8'h05, 1, 0);
    cmd(cab_pkg::CMD_LOAD_TEMP, 8'h34);
    cmd(cab_pkg::CMD_JUMP, 8'h12);
    fetch(8'h00, 0, 0);
    chk({18'h0, tmp}, {18'h0, 8'h34});
    sel = cab_pkg::DOUT_PC_HI;
    cmd(cab_pkg::CMD_PUSH, 8'h00);
    sel = cab_pkg::DOUT_PC_LO;
    cmd(cab_pkg::CMD_PUSH, 8'h00);
    sel = cab_pkg::DOUT_REGS;
    cmd(cab_pkg::CMD_POP, 8'h00);
    cmd(cab_pkg::CMD_POP, 8'h00);
    cmd(cab_pkg::CMD_LOAD_SP_HI, 8'h01);
    cmd(cab_pkg::CMD_LOAD_SP_LO, 8'h00);
    cmd(cab_pkg::CMD_PUSH, 8'h00);
    cmd(cab_pkg::CMD_POP, 8'h00);
    fc.user_set = 4'h5;
    idles(2);
    fc.user_set = 4'h2;
    fc.user_clear = 4'h3;
    fc.mask_clear = 1;
    fc.alu_load = 1;
    fc.alu_nzc = 3'h5;
    idles(3);
    chk({18'h0, status_flags_word}, {18'h0, 8'h65});
    fetch(8'h0c, 1, 2);
    repeat (80)
    begin
      sel = cab_pkg::cab_dout_sel_t'(rnd() % 3);
      cmd(cab_pkg::cab_cmd_t'(rnd() % 10 + 1), 8'(rnd()));
    end
    idles(3);
    chk(26'(exq.size()), 26'h0);
    test_done;
  end
endmodule
bind cab_address_unit cab_chk chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_ready(i_ready), .i_ctrl(i_ctrl), .i_input_data_bus(i_input_data_bus),
  .i_interrupt_request(i_interrupt_request), .i_flag_ctl(i_flag_ctl),
  .o_next_address(o_next_address), .o_address(o_address), .o_read(o_read),
  .o_write(o_write), .o_opcode_fetch_strobe(o_opcode_fetch_strobe), .o_opcode(o_opcode),
  .o_int_accepted(o_int_accepted), .o_program_counter(o_program_counter),
  .o_stack_pointer(o_stack_pointer), .o_status_flags_word(o_status_flags_word));
`default_nettype wire
